/* hdl/atu_pkg.sv */
/*
  atu_pkg: shared constants for the acquisition trigger unit.
  assumes a 25 MHz system clock and an avalon-mm register slave.
*/
package atu_pkg;
  // ===========================================================
  // register word offsets (byte addresses)
  localparam logic [7:0] ATU_OFS_SRC      = 8'h00;
  localparam logic [7:0] ATU_OFS_MODE     = 8'h04;
  localparam logic [7:0] ATU_OFS_CMD      = 8'h08;
  localparam logic [7:0] ATU_OFS_LEVEL    = 8'h0C;
  localparam logic [7:0] ATU_OFS_PATTERN  = 8'h10;
  localparam logic [7:0] ATU_OFS_TIMEDIV  = 8'h14;
  localparam logic [7:0] ATU_OFS_TSTART   = 8'h18;
  localparam logic [7:0] ATU_OFS_TSTOP    = 8'h1C;
  localparam logic [7:0] ATU_OFS_TINTV    = 8'h20;
  localparam logic [7:0] ATU_OFS_STATUS   = 8'h24;
  localparam logic [7:0] ATU_OFS_NOW      = 8'h28;
  localparam logic [7:0] ATU_OFS_TRIGPOS  = 8'h2C;
  // ===========================================================
  // source enable bit positions
  localparam int ATU_SRC_CH0    = 0;
  localparam int ATU_SRC_EXT    = 3;
  localparam int ATU_SRC_MAN    = 4;
  localparam int ATU_SRC_TIMER  = 5;
  // mode register fields
  localparam int ATU_MODE_LSB   = 0;
  localparam int ATU_PRE_LSB    = 2;
  localparam int ATU_SLOPE_LSB  = 6;
  localparam int ATU_AFILT_LSB  = 8;
  localparam int ATU_LFILT_LSB  = 12;
  localparam int ATU_COMB_BIT   = 16;
  localparam int ATU_POL_BIT    = 17;
  localparam int ATU_FFT_BIT    = 18;
  // command bits
  localparam int ATU_CMD_START  = 0;
  localparam int ATU_CMD_STOP   = 1;
  localparam int ATU_CMD_MANUAL = 2;
  // ===========================================================
  // reset values
  localparam logic [31:0] ATU_SRC_RST     = 32'h0000_0000;
  localparam logic [31:0] ATU_MODE_RST    = 32'h0000_0000;
  localparam logic [31:0] ATU_LEVEL_RST   = 32'h0032_3232;
  localparam logic [31:0] ATU_PATTERN_RST = 32'h0000_0000;
  localparam logic [31:0] ATU_TIMEDIV_RST = 32'h0000_0001;
  // ===========================================================
  // timing and sizes
  localparam int          ATU_CLK_HZ      = 25_000_000;
  localparam int          ATU_TICK_US     = 1;
  localparam int          ATU_TICK_CYC    = ATU_CLK_HZ / 1_000_000 *
                                            ATU_TICK_US;
  localparam int          ATU_DIVS        = 20;
  localparam logic [31:0] ATU_AUTO_MAX_US = 32'd2_000_000;
  localparam logic [9:0]  ATU_FFT_LEN     = 10'h3FF;  // 1024 minus one
  localparam int          ATU_LEN_W       = 10;
  localparam logic [7:0]  ATU_PCT_FULL    = 8'h64;

  typedef enum logic [1:0] {
    ATU_SINGLE = 2'b00,
    ATU_REPEAT = 2'b01,
    ATU_AUTO   = 2'b10
  } atu_mode_e;

  typedef enum logic [1:0] {
    ATU_IDLE = 2'b00,
    ATU_ARM  = 2'b01,
    ATU_CAPT = 2'b10,
    ATU_HOLD = 2'b11
  } atu_state_e;

  // pretrigger step table, percent of record
  function automatic logic [7:0] atu_pre_pct(input logic [3:0] sel);
    case (sel)
      4'h0:    atu_pre_pct = 8'd0;
      4'h1:    atu_pre_pct = 8'd2;
      4'h2:    atu_pre_pct = 8'd5;
      4'h3:    atu_pre_pct = 8'd10;
      4'h4:    atu_pre_pct = 8'd20;
      4'h5:    atu_pre_pct = 8'd30;
      4'h6:    atu_pre_pct = 8'd40;
      4'h7:    atu_pre_pct = 8'd50;
      4'h8:    atu_pre_pct = 8'd60;
      4'h9:    atu_pre_pct = 8'd70;
      4'hA:    atu_pre_pct = 8'd80;
      4'hB:    atu_pre_pct = 8'd90;
      4'hC:    atu_pre_pct = 8'd95;
      default: atu_pre_pct = 8'd100;
    endcase
  endfunction

  // filter window in samples, zero means off
  function automatic logic [7:0] atu_filt_len(input logic [3:0] sel);
    case (sel)
      4'h1:    atu_filt_len = 8'd3;
      4'h2:    atu_filt_len = 8'd4;
      4'h3:    atu_filt_len = 8'd6;
      4'h4:    atu_filt_len = 8'd10;
      4'h5:    atu_filt_len = 8'd18;
      4'h6:    atu_filt_len = 8'd34;
      4'h7:    atu_filt_len = 8'd66;
      4'h8:    atu_filt_len = 8'd130;
      default: atu_filt_len = 8'd0;
    endcase
  endfunction
endpackage

/* hdl/atu_filter.sv */
/*
  atu_filter: trigger noise filter. fires when the condition stays
  set for the whole window. assumes one evaluation per sample strobe.
*/
`timescale 1ns/1ps
module atu_filter (
  input  wire logic       i_clock,   // system clock
  input  wire logic       i_rst_n,   // synchronised reset, low active
  input  wire logic       i_sample,  // sample strobe
  input  wire logic       i_clear,   // restart window
  input  wire logic [3:0] i_sel,     // window select, 0 is off
  input  wire logic       i_cond,    // raw condition level
  input  wire logic       i_edge,    // raw condition onset pulse
  output logic            o_fire     // qualified trigger pulse
);
  import atu_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic       fire;
  } atu_flt_s;

  atu_flt_s st_r;
  atu_flt_s st_nxt;
  logic [7:0] len;

  // ===========================================================
  // window counter
  always_comb begin
    len = atu_filt_len(i_sel);
    st_nxt = st_r;
    st_nxt.fire = 1'b0;
    if (i_clear) begin
      st_nxt.cnt = '0;
    end else if (i_sample) begin
      if (len == 8'h00) begin
        st_nxt.fire = i_edge;
      end else if (!i_cond) begin
        st_nxt.cnt = '0;
      end else if (st_r.cnt + 8'h01 == len) begin
        st_nxt.fire = 1'b1;
        st_nxt.cnt = st_r.cnt + 8'h01;
      end else if (st_r.cnt < len) begin
        st_nxt.cnt = st_r.cnt + 8'h01;
      end
    end
  end

  // state register
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_fire = st_r.fire;
endmodule // atu_filter

/* hdl/atu_timer.sv */
/*
  atu_timer: timer trigger source on a seconds count.
  assumes i_now is the seconds count kept by the top.
*/
`timescale 1ns/1ps
module atu_timer (
  input  wire logic        i_clock,   // system clock
  input  wire logic        i_rst_n,   // synchronised reset
  input  wire logic        i_start,   // start command pulse
  input  wire logic        i_enable,  // timer source on
  input  wire logic        i_single,  // single trigger mode
  input  wire logic [31:0] i_now,     // current seconds
  input  wire logic [31:0] i_tstart,  // start time
  input  wire logic [31:0] i_tstop,   // stop time
  input  wire logic [31:0] i_intv,    // interval, 0 for once
  output logic             o_fire     // timer event pulse
);
  import atu_pkg::*;

  typedef struct packed {
    logic        run;
    logic        stop_ok;
    logic [31:0] next;
    logic        fire;
  } atu_tmr_s;

  atu_tmr_s st_r;
  atu_tmr_s st_nxt;

  // ===========================================================
  // schedule
  always_comb begin
    st_nxt = st_r;
    st_nxt.fire = 1'b0;
    if (i_start) begin
      st_nxt.run = i_enable && (i_tstart > i_now);
      st_nxt.stop_ok = i_tstop > i_now;
      st_nxt.next = i_tstart;
    end else if (st_r.run && i_enable) begin
      if (st_r.stop_ok && i_now >= i_tstop) begin
        st_nxt.run = 1'b0;
      end else if (i_now >= st_r.next) begin
        st_nxt.fire = 1'b1;
        st_nxt.next = st_r.next + i_intv;
        if (i_intv == 32'h0000_0000 || i_single) begin
          st_nxt.run = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_fire = st_r.fire;
endmodule // atu_timer

/* hdl/atu_top.sv */
/*
  atu_top: acquisition trigger unit with avalon-mm register slave.
  assumes samples arrive synchronous to i_clock with a valid strobe.
*/
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module atu_top (
  input  wire logic        i_clock,          // 25 MHz clock
  input  wire logic        i_rst_n,          // async reset, low
  input  wire logic [7:0]  i_address,        // avalon byte address
  input  wire logic        i_read,           // avalon read
  input  wire logic        i_write,          // avalon write
  input  wire logic [31:0] i_writedata,      // avalon write data
  output logic [31:0]      o_readdata,       // avalon read data
  output logic             o_waitrequest,    // avalon wait
  input  wire logic        i_sample_valid,   // new sample strobe
  input  wire logic [7:0]  i_ch1_sample,     // analog ch1, 0..100
  input  wire logic [7:0]  i_ch2_sample,     // analog ch2, 0..100
  input  wire logic [3:0]  i_logic_in,       // logic ch3 inputs
  input  wire logic        i_ext_trig,       // external trigger level
  input  wire logic        i_manual_trigger_key, // manual key pulse
  input  wire logic        i_printing,       // record being printed
  output logic             o_acq_start,      // acquisition start
  output logic             o_capturing,      // record in progress
  output logic             o_wr_en,          // buffer write
  output logic [9:0]       o_wr_addr         // circular buffer index
);
  import atu_pkg::*;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] mode;
    logic [31:0] level;
    logic [31:0] pattern;
    logic [31:0] timediv;
    logic [31:0] tstart;
    logic [31:0] tstop;
    logic [31:0] tintv;
    logic        ack;
    logic [31:0] rdata;
    atu_state_e  state;
    logic [4:0]  tick_div;
    logic [19:0] usec;
    logic [31:0] now;
    logic [31:0] auto_cnt;
    logic [9:0]  wptr;
    logic [9:0]  post_cnt;
    logic [9:0]  trig_pos;
    logic [1:0]  above_prev;
    logic        ext_prev;
    logic        lmatch_prev;
    logic        start_p;
    logic        acq;
  } atu_top_s;

  atu_top_s   st_r;
  atu_top_s   st_nxt;
  logic [1:0] rst_sync_r;
  logic       rst_n;
  logic       wr_hit;
  logic       start_cmd;
  logic       man_cmd;
  logic [1:0] above;
  logic [1:0] ch_edge;
  logic [2:0] ch_fire;
  logic       a_match;
  logic       b_match;
  logic       lmatch;
  logic       ext_edge;
  logic       tmr_fire;
  logic       any_src;
  logic       trig;
  logic [31:0] auto_lim;
  logic [9:0]  rec_len;
  logic [9:0]  post_len;
  logic [17:0] pre_prod;

  assign rst_n = rst_sync_r[1];

  // ===========================================================
  // reset release, two flops
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  // pattern check, X bits ignored (pattern care/value nibbles)
  function automatic logic atu_pat(input logic [3:0] val,
                                   input logic [3:0] care,
                                   input logic [3:0] din);
    atu_pat = ((din ^ val) & care) == 4'h0;
  endfunction

  // ===========================================================
  // trigger sources
  // a write commits at the edge where wait is seen low
  assign wr_hit    = i_write && st_r.ack;
  assign start_cmd = wr_hit && i_address == ATU_OFS_CMD &&
                     i_writedata[ATU_CMD_START];
  assign man_cmd   = wr_hit && i_address == ATU_OFS_CMD &&
                     i_writedata[ATU_CMD_MANUAL];
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      above[i] = (i == 0 ? i_ch1_sample : i_ch2_sample) >=
                 st_r.level[8*i +: 8];
      ch_edge[i] = st_r.mode[ATU_SLOPE_LSB+i] ?
                   (st_r.above_prev[i] && !above[i]) :
                   (!st_r.above_prev[i] && above[i]);
    end
    a_match = atu_pat(st_r.pattern[3:0], st_r.pattern[7:4], i_logic_in);
    b_match = atu_pat(st_r.pattern[11:8], st_r.pattern[15:12],
                      i_logic_in);
    lmatch = st_r.mode[ATU_COMB_BIT] ? (a_match || b_match) :
                                       (a_match && b_match);
    lmatch = lmatch ^ st_r.mode[ATU_POL_BIT];
  end

  // analog channel filters
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_afilt
      atu_filter u_filt (
        .i_clock  (i_clock),
        .i_rst_n  (rst_n),
        .i_sample (i_sample_valid),
        .i_clear  (start_cmd || !st_r.above_prev[g] && !above[g] &&
                   1'b0),
        .i_sel    (st_r.mode[ATU_AFILT_LSB +: 4]),
        .i_cond   (st_r.mode[ATU_SLOPE_LSB+g] ? !above[g] : above[g]),
        .i_edge   (ch_edge[g]),
        .o_fire   (ch_fire[g])
      );
    end
  endgenerate

  atu_filter u_lfilt (
    .i_clock  (i_clock),
    .i_rst_n  (rst_n),
    .i_sample (i_sample_valid),
    .i_clear  (start_cmd),
    .i_sel    (st_r.mode[ATU_LFILT_LSB +: 4]),
    .i_cond   (lmatch),
    .i_edge   (lmatch && !st_r.lmatch_prev),
    .o_fire   (ch_fire[2])
  );

  atu_timer u_timer (
    .i_clock  (i_clock),
    .i_rst_n  (rst_n),
    .i_start  (start_cmd),
    .i_enable (st_r.src[ATU_SRC_TIMER]),
    .i_single (st_r.mode[ATU_MODE_LSB +: 2] == ATU_SINGLE),
    .i_now    (st_r.now),
    .i_tstart (st_r.tstart),
    .i_tstop  (st_r.tstop),
    .i_intv   (st_r.tintv),
    .o_fire   (tmr_fire)
  );

  assign ext_edge = i_ext_trig && !st_r.ext_prev;

  // ===========================================================
  // combine sources and sizing
  always_comb begin
    any_src = |st_r.src[ATU_SRC_TIMER:ATU_SRC_CH0];
    trig = |(ch_fire & st_r.src[ATU_SRC_CH0 +: 3]) ||
           (ext_edge && st_r.src[ATU_SRC_EXT]) ||
           ((i_manual_trigger_key || man_cmd) && st_r.src[ATU_SRC_MAN]) ||
           (tmr_fire && st_r.src[ATU_SRC_TIMER]);
    auto_lim = st_r.timediv * 32'(ATU_DIVS);
    if (auto_lim > ATU_AUTO_MAX_US) begin
      auto_lim = ATU_AUTO_MAX_US;
    end
    rec_len = ATU_FFT_LEN;
    pre_prod = 18'(rec_len) * 18'(atu_pre_pct(st_r.mode[ATU_PRE_LSB +: 4]));
    post_len = rec_len - 10'(pre_prod / 18'(ATU_PCT_FULL));
  end

  // ===========================================================
  // registers, bus, sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.acq = 1'b0;
    st_nxt.start_p = start_cmd;
    // bus slave: one wait state per access
    if ((i_read || i_write) && !st_r.ack) begin
      st_nxt.ack = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      unique case (i_address)
        ATU_OFS_SRC:     st_nxt.rdata = st_r.src;
        ATU_OFS_MODE:    st_nxt.rdata = st_r.mode;
        ATU_OFS_LEVEL:   st_nxt.rdata = st_r.level;
        ATU_OFS_PATTERN: st_nxt.rdata = st_r.pattern;
        ATU_OFS_TIMEDIV: st_nxt.rdata = st_r.timediv;
        ATU_OFS_TSTART:  st_nxt.rdata = st_r.tstart;
        ATU_OFS_TSTOP:   st_nxt.rdata = st_r.tstop;
        ATU_OFS_TINTV:   st_nxt.rdata = st_r.tintv;
        ATU_OFS_STATUS:  st_nxt.rdata = {30'h0, st_r.state};
        ATU_OFS_NOW:     st_nxt.rdata = st_r.now;
        ATU_OFS_TRIGPOS: st_nxt.rdata = {22'h0, st_r.trig_pos};
        default:         st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_hit) begin
      unique case (i_address)
        ATU_OFS_SRC:     st_nxt.src = i_writedata;
        ATU_OFS_MODE:    st_nxt.mode = i_writedata;
        ATU_OFS_LEVEL:   st_nxt.level = i_writedata;
        ATU_OFS_PATTERN: st_nxt.pattern = i_writedata;
        ATU_OFS_TIMEDIV: st_nxt.timediv = i_writedata;
        ATU_OFS_TSTART:  st_nxt.tstart = i_writedata;
        ATU_OFS_TSTOP:   st_nxt.tstop = i_writedata;
        ATU_OFS_TINTV:   st_nxt.tintv = i_writedata;
        ATU_OFS_NOW:     st_nxt.now = i_writedata;
        default:         st_nxt.rdata = st_nxt.rdata;
      endcase
    end
    // microsecond and second time base
    st_nxt.tick_div = (st_r.tick_div == 5'(ATU_TICK_CYC - 1)) ? 5'h00 :
                      st_r.tick_div + 5'h01;
    if (st_r.tick_div == 5'h00) begin
      st_nxt.usec = (st_r.usec == 20'd999_999) ? 20'h00000 :
                    st_r.usec + 20'h00001;
      if (st_r.usec == 20'd999_999) begin
        st_nxt.now = st_r.now + 32'h0000_0001;
      end
    end
    if (i_sample_valid) begin
      st_nxt.above_prev = above;
      st_nxt.ext_prev = i_ext_trig;
      st_nxt.lmatch_prev = lmatch;
    end
    // sequencer
    unique case (st_r.state)
      ATU_IDLE: begin
        if (start_cmd) begin
          st_nxt.state = ATU_ARM;
          st_nxt.auto_cnt = '0;
        end
      end
      ATU_ARM: begin
        if (st_r.tick_div == 5'h00) begin
          st_nxt.auto_cnt = st_r.auto_cnt + 32'h0000_0001;
        end
        if (!i_printing && ((any_src && trig) ||
            (!any_src && st_r.start_p) ||
            (st_r.mode[ATU_MODE_LSB +: 2] == ATU_AUTO &&
             st_r.auto_cnt >= auto_lim))) begin
          st_nxt.acq = 1'b1;
          st_nxt.state = ATU_CAPT;
          st_nxt.post_cnt = post_len;
          st_nxt.trig_pos = st_r.wptr;
        end
      end
      ATU_CAPT: begin
        if (i_sample_valid) begin
          if (st_r.post_cnt == 10'h000) begin
            st_nxt.state = (st_r.mode[ATU_MODE_LSB +: 2] == ATU_SINGLE) ?
                           ATU_HOLD : ATU_ARM;
            st_nxt.auto_cnt = '0;
          end else begin
            st_nxt.post_cnt = st_r.post_cnt - 10'h001;
          end
        end
      end
      ATU_HOLD: begin
        if (start_cmd) begin
          st_nxt.state = ATU_ARM;
          st_nxt.auto_cnt = '0;
        end
      end
    endcase
    if (wr_hit && i_address == ATU_OFS_CMD && i_writedata[ATU_CMD_STOP]) begin
      st_nxt.state = ATU_IDLE;
    end
    if (i_sample_valid && st_r.state != ATU_IDLE) begin
      st_nxt.wptr = st_r.wptr + 10'h001;
    end
  end

  // state register
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r.src        <= ATU_SRC_RST;
      st_r.mode       <= ATU_MODE_RST;
      st_r.level      <= ATU_LEVEL_RST;
      st_r.pattern    <= ATU_PATTERN_RST;
      st_r.timediv    <= ATU_TIMEDIV_RST;
      st_r.tstart     <= '0;
      st_r.tstop      <= '0;
      st_r.tintv      <= '0;
      st_r.ack        <= 1'b0;
      st_r.rdata      <= '0;
      st_r.state      <= ATU_IDLE;
      st_r.tick_div   <= '0;
      st_r.usec       <= '0;
      st_r.now        <= '0;
      st_r.auto_cnt   <= '0;
      st_r.wptr       <= '0;
      st_r.post_cnt   <= '0;
      st_r.trig_pos   <= '0;
      st_r.above_prev <= '0;
      st_r.ext_prev   <= 1'b0;
      st_r.lmatch_prev <= 1'b0;
      st_r.start_p    <= 1'b0;
      st_r.acq        <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign o_waitrequest = (i_read || i_write) && !st_r.ack;
  assign o_readdata    = st_r.rdata;
  assign o_acq_start   = st_r.acq;
  assign o_capturing   = st_r.state == ATU_CAPT;
  assign o_wr_en       = i_sample_valid && st_r.state != ATU_IDLE;
  assign o_wr_addr     = st_r.wptr;
endmodule // atu_top

/* tb/atu_top_assertions.sv */
/* atu_top_assertions: port checks of the trigger unit.
   assumes one clock domain, bound onto atu_top. */
`timescale 1ns/1ps
module atu_top_assertions (
  input wire logic       i_clock,        // clock
  input wire logic       i_rst_n,        // reset, low
  input wire logic       i_read,         // bus read
  input wire logic       i_write,        // bus write
  input wire logic       o_waitrequest,  // bus wait
  input wire logic       i_sample_valid, // sample strobe
  input wire logic       i_printing,     // print busy
  input wire logic       o_acq_start,    // start pulse
  input wire logic       o_capturing,    // record busy
  input wire logic       o_wr_en,        // buffer write
  input wire logic [9:0] o_wr_addr       // buffer index
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // ==========================
  // bus handshake and trigger gating
  chk_wait_first: assert property ((i_read || i_write) &&
    !$past(i_read || i_write) |-> o_waitrequest) else $error("no wait");
  chk_wait_one: assert property ((i_read || i_write) && o_waitrequest
    |=> !o_waitrequest) else $error("wait too long");
  chk_start_pulse: assert property (
    o_acq_start |=> !o_acq_start[*2]) else $error("start repeats");
  chk_start_capt: assert property (
    o_acq_start |-> o_capturing) else $error("start without record");
  chk_print_block: assert property (
    $past(i_printing) |-> !o_acq_start) else $error("start in print");
  chk_capt_block: assert property (
    o_capturing && $past(o_capturing) |-> !o_acq_start)
    else $error("start in record");
  // ==========================
  // circular buffer stepping
  chk_wr_capt: assert property (
    i_sample_valid && o_capturing |-> o_wr_en) else $error("no store");
  chk_addr_step: assert property (
    o_wr_en && !i_write |=> o_wr_addr == $past(o_wr_addr) + 10'h001)
    else $error("index not stepped");
  chk_addr_hold: assert property (
    !o_wr_en && !i_write |=> $stable(o_wr_addr)) else $error("index moved");
endmodule // atu_top_assertions
bind atu_top atu_top_assertions atu_top_assertions_i (.i_clock, .i_rst_n,
  .i_read, .i_write, .o_waitrequest, .i_sample_valid, .i_printing,
  .o_acq_start, .o_capturing, .o_wr_en, .o_wr_addr);

/* tb/atu_src_model.sv */
/* atu_src_model: sampled channel source for the trigger unit.
   assumes one clock; samples change right after a rising edge. */
`timescale 1ns/1ps
module atu_src_model (
  input  wire logic       i_clock, // clock
  input  wire logic       i_ramp,  // lift ch1 above level
  output logic            o_valid, // sample strobe
  output logic [7:0]      o_ch1,   // ch1 percent
  output logic [7:0]      o_ch2,   // ch2 percent
  output logic [3:0]      o_logic  // logic inputs
);
  initial begin
    o_valid = 1'b0;
    o_ch1 = 8'h28;
    o_ch2 = 8'h0A;
    o_logic = 4'h0;
  end
  // one sample every second cycle, ch1 at 40 or 60, logic 0 or 5
  always @(posedge i_clock) begin
    o_valid <= !o_valid;
    if (!o_valid) begin
      o_ch1 <= i_ramp ? 8'h3C : 8'h28;
      o_logic <= i_ramp ? 4'h5 : 4'h0;
    end
  end
endmodule // atu_src_model

/* tb/tb_atu_top.sv */
/* tb_atu_top: register and trigger scenarios for atu_top.
   assumes atu_src_model feeds the sample inputs. */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
  n_mismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
  end end
module tb_atu_top;
  import atu_pkg::*;
  logic        i_clock, i_rst_n, i_read, i_write, i_sample_valid;
  logic        i_ext_trig, i_manual_trigger_key, i_printing, ramp;
  logic [7:0]  i_address, i_ch1_sample, i_ch2_sample;
  logic [3:0]  i_logic_in;
  logic [31:0] i_writedata, o_readdata, q;
  logic        o_waitrequest, o_acq_start, o_capturing, o_wr_en;
  logic [9:0]  o_wr_addr;
  int          n_mismatch = 0, num_checks = 0;
  atu_top atu_top_i (.i_clock, .i_rst_n, .i_address, .i_read, .i_write,
    .i_writedata, .o_readdata, .o_waitrequest, .i_sample_valid,
    .i_ch1_sample, .i_ch2_sample, .i_logic_in, .i_ext_trig,
    .i_manual_trigger_key, .i_printing, .o_acq_start, .o_capturing,
    .o_wr_en, .o_wr_addr);
  atu_src_model atu_src_model_i (.i_clock, .i_ramp(ramp),
    .o_valid(i_sample_valid), .o_ch1(i_ch1_sample),
    .o_ch2(i_ch2_sample), .o_logic(i_logic_in));
  task automatic complete_run();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // one bus access, held until wait is seen low at an edge
  task automatic bus(input logic rd, input logic [7:0] a,
                     input logic [31:0] d);
    logic ok;
    ok = 1'b0;
    @(posedge i_clock);
    {i_read, i_write, i_address, i_writedata} <= {rd, !rd, a, d};
    for (int k = 0; k < 20 && !ok; k++) begin
      @(posedge i_clock);
      if (o_waitrequest === 1'b0) begin
        ok = 1'b1;
        q = o_readdata;
      end
    end
    {i_read, i_write} <= 2'b00;
    if (!ok) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  // drive how = {ramp, print, key, ext} for n cycles, watch for a start
  task automatic trig(input logic want, input int n, input logic [3:0] how);
    logic seen;
    seen = 1'b0;
    @(posedge i_clock);
    {ramp, i_printing, i_manual_trigger_key, i_ext_trig} <= how;
    for (int k = 0; k < n; k++) begin
      @(negedge i_clock);
      seen |= (o_acq_start === 1'b1);
      @(posedge i_clock);
      i_manual_trigger_key <= 1'b0;
    end
    @(posedge i_clock);
    {ramp, i_printing, i_ext_trig} <= 3'b000;
    `CHK(seen, want)
    if (want && !seen) complete_run();
  endtask
  // bounded wait for the record to finish
  task automatic idle();
    for (int k = 0; o_capturing !== 1'b0; k++) begin
      @(negedge i_clock);
      if (k > 5000) begin
        n_mismatch++;
        complete_run();
      end
    end
  endtask
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // reset, then the scenario sequence
  initial begin
    {i_rst_n, i_read, i_write, i_ext_trig, i_manual_trigger_key} = '0;
    {i_printing, ramp, i_address, i_writedata} = '0;
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clock);
    bus(1, ATU_OFS_LEVEL, 32'h0);
    `CHK(q, ATU_LEVEL_RST)
    bus(1, ATU_OFS_TIMEDIV, 32'h0);
    `CHK(q, ATU_TIMEDIV_RST)
    bus(0, 8'h30, 32'hFFFF_FFFF);
    bus(1, 8'h30, 32'h0);
    `CHK(q, 32'h0000_0000)
    bus(0, ATU_OFS_CMD, 32'h1);
    trig(1, 40, 4'h0);
    idle();
    bus(0, ATU_OFS_SRC, 32'h8);
    bus(0, ATU_OFS_CMD, 32'h1);
    trig(1, 100, 4'h1);
    idle();
    trig(0, 100, 4'h1);
    bus(0, ATU_OFS_MODE, 32'h1);
    bus(0, ATU_OFS_SRC, 32'h18);
    bus(0, ATU_OFS_CMD, 32'h1);
    trig(1, 100, 4'h1);
    trig(0, 100, 4'h1);
    idle();
    trig(0, 100, 4'h5);
    trig(1, 100, 4'h2);
    idle();
    bus(0, ATU_OFS_SRC, 32'h1);
    trig(1, 100, 4'h8);
    idle();
    bus(0, ATU_OFS_MODE, 32'h41);
    trig(0, 100, 4'h8);
    trig(1, 100, 4'h0);
    idle();
    bus(0, ATU_OFS_PATTERN, 32'hF5);
    bus(0, ATU_OFS_SRC, 32'h4);
    bus(0, ATU_OFS_MODE, 32'h1035);
    trig(1, 100, 4'h8);
    `CHK(o_capturing, 1'b0)
    bus(0, ATU_OFS_MODE, 32'h1);
    bus(0, ATU_OFS_SRC, 32'h20);
    bus(0, ATU_OFS_TSTART, 32'h1);
    bus(0, ATU_OFS_CMD, 32'h1);
    bus(0, ATU_OFS_NOW, 32'h1);
    repeat (3) @(posedge i_clock);
    `CHK(o_capturing, 1'b1)
    idle();
    bus(0, ATU_OFS_NOW, 32'h2);
    repeat (3) @(posedge i_clock);
    `CHK(o_capturing, 1'b0)
    bus(0, ATU_OFS_SRC, 32'h8);
    bus(0, ATU_OFS_MODE, 32'h2);
    bus(0, ATU_OFS_CMD, 32'h2);
    bus(0, ATU_OFS_CMD, 32'h1);
    trig(0, 400, 4'h0);
    trig(1, 200, 4'h0);
    complete_run();
  end
endmodule // tb_atu_top
